// [core/pmwd_pkg.sv]
/*
 * pmwd_pkg: shared constants for the power-management watchdog block.
 * Assumes a 40 MHz system clock; all counts derived from that rate.
 */
package pmwd_pkg;
    // ------------------------------------------------------------------
    // register indexes behind the index/data pair
    // ------------------------------------------------------------------
    localparam logic [2:0] IDX_CLOCK_GATE_CONTROL = 3'h4;
    localparam logic [2:0] IDX_TIMEOUT_PERIOD = 3'h5;
    localparam logic [2:0] IDX_TRIGGER_CONFIG = 3'h6;
    localparam logic [2:0] IDX_TIMEOUT_STATUS = 3'h7;
    // port selector: 0 = index port, 1 = data port
    localparam logic PORT_INDEX = 1'b0;
    localparam logic PORT_DATA = 1'b1;
    // ------------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CLOCK_GATE_CONTROL = 8'h0e;
    localparam logic [7:0] RST_TIMEOUT_PERIOD = 8'h00;
    localparam logic [3:0] RST_TRIGGER_CONFIG = 4'h0;
    localparam logic [7:0] RST_TIMEOUT_STATUS = 8'h01;
    localparam logic [2:0] RST_INDEX = 3'h0;
    localparam int GATE_PARALLEL_BIT = 1;
    localparam int GATE_SECOND_SERIAL_BIT = 2;
    localparam int GATE_FIRST_SERIAL_BIT = 3;
    localparam int BUSY_SECOND_SERIAL_BIT = 6;
    localparam int BUSY_FIRST_SERIAL_BIT = 7;
    localparam int TRIGGER_COUNT = 4;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam longint CLOCK_HZ = 40000000;
    localparam longint TICK_SECONDS = 60;
    localparam longint TICK_CYCLES = CLOCK_HZ * TICK_SECONDS;
endpackage : pmwd_pkg

// [core/pmwd_prescaler.sv]
/*
 * pmwd_prescaler: divides the system clock down to a one-minute tick.
 * Assumes restart is asserted whenever the countdown reloads or clears.
 */
`timescale 1ns/1ps
`default_nettype none
module pmwd_prescaler #(
    parameter logic [31:0] TICK_CYCLES = 32'd2400000000
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // control
    input wire logic restart,
    input wire logic run,
    // tick out
    output logic tick
);
    // cycles elapsed in the current minute
    logic [31:0] count;

    // ------------------------------------------------------------------
    // divider
    // ------------------------------------------------------------------
    // restart keeps a fresh reload from getting a short first minute
    always_ff @(posedge mclk)
    begin
        if (sys_rst || restart || !run)
        begin
            count <= 32'h0;
            tick <= 1'b0;
        end
        else if (count == TICK_CYCLES - 32'h1)
        begin
            count <= 32'h0;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule : pmwd_prescaler
`default_nettype wire

// [core/pmwd_top.sv]
/*
 * pmwd_top: power-management clock gates and inactivity watchdog,
 * reached through an index/data port pair.
 * Assumes synchronous host strobes, one cycle each, and interrupt
 * inputs already resolved to logical activity (high = active).
 */
// Function
// - clock gate register resets to 0x0e
// - parallel clock needs gate bit1 and config
// - second serial clock needs bit2 and config
// - first serial clock needs bit3 and config
// - bits 6,7 read serial busy flags
// - period reads programmed value, not countdown
// - period clears on reset and activation
// - writing zero stops countdown, output inactive
// - nonzero period loads, decrements each minute
// - reaching zero asserts output, stops counting
// - nonzero write returns output high
// - software reset deactivates device, resets watchdog
// - enabled trigger reloads programmed period
// - triggers use logical interrupt activity
// - four trigger enables select sources
// - trigger enables clear on reset, activation
// - status bit0 reads inverse of activity
// - status tracks timeout regardless of pin use
// - index port selects, data port accesses
// - index bits 7..3 read zero
`timescale 1ns/1ps
`default_nettype none
module pmwd_top
    import pmwd_pkg::*;
#(
    parameter logic [31:0] MINUTE_CYCLES = 32'(TICK_CYCLES)
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // host index/data port
    input wire logic host_sel,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    // logical device control
    input wire logic soft_reset,
    input wire logic pm_activate,
    output logic pm_active,
    // per-port configuration clock bits and busy flags
    input wire logic parallel_cfg_clk_en,
    input wire logic second_serial_cfg_clk_en,
    input wire logic first_serial_cfg_clk_en,
    input wire logic second_serial_busy,
    input wire logic first_serial_busy,
    // clock gate outputs
    output logic parallel_clk_en,
    output logic second_serial_clk_en,
    output logic first_serial_clk_en,
    // trigger sources
    input wire logic keyboard_irq_active,
    input wire logic mouse_irq_active,
    input wire logic first_serial_irq_active,
    input wire logic second_serial_irq_active,
    // timeout
    output logic inactivity_timeout_out_n
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum {WD_IDLE, WD_COUNT, WD_EXPIRED} pmwd_state_type;
    pmwd_state_type state; // watchdog phase
    logic [2:0] index_reg; // selected register
    logic [3:0] gate_bits; // writable gate bits 3..1
    logic [7:0] timeout_period; // programmed period
    logic [7:0] countdown; // live count, not readable
    logic [3:0] trigger_config; // trigger enables
    logic [3:0] trig_src; // raw trigger sources
    logic [3:0] trig_hit; // enabled active sources
    logic data_wr; // write to data port
    logic period_wr; // write to period register
    logic reinit; // activation or software reset
    logic minute_tick; // one per minute
    logic restart_tick; // restarts prescaler
    logic [7:0] next_rdata; // read mux

    assign data_wr = host_wr && host_sel == PORT_DATA;
    assign period_wr = data_wr && index_reg == IDX_TIMEOUT_PERIOD;
    assign reinit = pm_activate || soft_reset;
    assign trig_src = {second_serial_irq_active, first_serial_irq_active,
                       mouse_irq_active, keyboard_irq_active};

    // ------------------------------------------------------------------
    // trigger qualification
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < TRIGGER_COUNT; gi++)
        begin : g_trig
            // only the logical level matters, not pin polarity
            assign trig_hit[gi] = trigger_config[gi] && trig_src[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // logical device active flag
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst || soft_reset)
            pm_active <= 1'b0;
        else if (pm_activate)
            pm_active <= 1'b1;
    end

    // ------------------------------------------------------------------
    // index port
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            index_reg <= RST_INDEX;
        else if (host_wr && host_sel == PORT_INDEX)
            index_reg <= host_wdata[2:0]; // upper bits dropped
    end

    // ------------------------------------------------------------------
    // clock gate control register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            gate_bits <= RST_CLOCK_GATE_CONTROL[3:0];
        else if (data_wr && index_reg == IDX_CLOCK_GATE_CONTROL)
            gate_bits <= {host_wdata[3:1], 1'b0}; // bit0 reserved
    end

    // ------------------------------------------------------------------
    // gated clock enables, registered
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            parallel_clk_en <= 1'b0;
            second_serial_clk_en <= 1'b0;
            first_serial_clk_en <= 1'b0;
        end
        else
        begin
            parallel_clk_en <= gate_bits[GATE_PARALLEL_BIT]
                && parallel_cfg_clk_en;
            second_serial_clk_en <= gate_bits[GATE_SECOND_SERIAL_BIT]
                && second_serial_cfg_clk_en;
            first_serial_clk_en <= gate_bits[GATE_FIRST_SERIAL_BIT]
                && first_serial_cfg_clk_en;
        end
    end

    // ------------------------------------------------------------------
    // trigger configuration register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst || reinit)
            trigger_config <= RST_TRIGGER_CONFIG;
        else if (data_wr && index_reg == IDX_TRIGGER_CONFIG)
            trigger_config <= host_wdata[3:0]; // high nibble ignored
    end

    // ------------------------------------------------------------------
    // timeout period register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst || reinit)
            timeout_period <= RST_TIMEOUT_PERIOD;
        else if (period_wr)
            timeout_period <= host_wdata;
    end

    // ------------------------------------------------------------------
    // watchdog countdown
    // ------------------------------------------------------------------
    // a write has priority over a same-cycle trigger or tick
    always_ff @(posedge mclk)
    begin
        if (sys_rst || reinit)
        begin
            state <= WD_IDLE;
            countdown <= 8'h00;
        end
        else if (period_wr)
        begin
            if (host_wdata == 8'h00)
            begin
                state <= WD_IDLE;
                countdown <= 8'h00;
            end
            else
            begin
                state <= WD_COUNT;
                countdown <= host_wdata;
            end
        end
        else
        begin
            case (state)
                WD_COUNT:
                begin
                    if (|trig_hit)
                        countdown <= timeout_period;
                    else if (minute_tick)
                    begin
                        countdown <= countdown - 8'h01;
                        if (countdown == 8'h01)
                            state <= WD_EXPIRED;
                    end
                end
                WD_EXPIRED:
                    state <= WD_EXPIRED; // stopped until rewrite
                WD_IDLE:
                    state <= WD_IDLE;
                default:
                    state <= WD_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // timeout output, active low
    // ------------------------------------------------------------------
    // status bit below reads the same flop, so it tracks even when the
    // pin is used for general purpose
    always_ff @(posedge mclk)
    begin
        if (sys_rst || reinit)
            inactivity_timeout_out_n <= 1'b1;
        else if (period_wr)
            inactivity_timeout_out_n <= 1'b1;
        else if (state == WD_COUNT && !(|trig_hit) && minute_tick
                 && countdown == 8'h01)
            inactivity_timeout_out_n <= 1'b0;
    end

    // ------------------------------------------------------------------
    // minute prescaler
    // ------------------------------------------------------------------
    assign restart_tick = period_wr || reinit || (|trig_hit);

    pmwd_prescaler #(
        .TICK_CYCLES(MINUTE_CYCLES)
    ) u_prescaler (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .restart(restart_tick),
        .run(state == WD_COUNT),
        .tick(minute_tick)
    );

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb
    begin
        next_rdata = 8'h00;
        if (host_sel == PORT_INDEX)
            next_rdata = {5'h00, index_reg};
        else
        begin
            case (index_reg)
                IDX_CLOCK_GATE_CONTROL:
                    next_rdata = {first_serial_busy, second_serial_busy,
                                  2'b00, gate_bits};
                IDX_TIMEOUT_PERIOD:
                    next_rdata = timeout_period;
                IDX_TRIGGER_CONFIG:
                    next_rdata = {4'h0, trigger_config};
                // same flop as the pin, whatever the pin is used for
                IDX_TIMEOUT_STATUS:
                    next_rdata = {7'h00,
                        inactivity_timeout_out_n};
                default:
                    next_rdata = 8'h00; // other indexes live elsewhere
            endcase
        end
    end

    // registered read data, valid the cycle after host_rd
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            host_rdata <= 8'h00;
        else if (host_rd)
            host_rdata <= next_rdata;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_gate_reset;
        @(posedge mclk) sys_rst |=> gate_bits == RST_CLOCK_GATE_CONTROL[3:0];
    endproperty
    a_gate_reset: assert property (p_gate_reset)
        else $error("gate register reset value wrong");

    property p_par_clk;
        @(posedge mclk) disable iff (sys_rst)
        parallel_clk_en |-> $past(gate_bits[1]) && $past(parallel_cfg_clk_en);
    endproperty
    a_par_clk: assert property (p_par_clk)
        else $error("parallel clock on without both enables");

    property p_ser2_clk;
        @(posedge mclk) disable iff (sys_rst)
        ##1 second_serial_clk_en == $past(gate_bits[2]
            && second_serial_cfg_clk_en);
    endproperty
    a_ser2_clk: assert property (p_ser2_clk)
        else $error("second serial clock gate wrong");

    property p_ser1_clk;
        @(posedge mclk) disable iff (sys_rst)
        !first_serial_cfg_clk_en |=> !first_serial_clk_en;
    endproperty
    a_ser1_clk: assert property (p_ser1_clk)
        else $error("first serial clock ran with config bit clear");

    property p_zero_write;
        @(posedge mclk) disable iff (sys_rst)
        period_wr && host_wdata == 8'h00 |=> state == WD_IDLE
            && inactivity_timeout_out_n;
    endproperty
    a_zero_write: assert property (p_zero_write)
        else $error("zero write did not stop watchdog");

    property p_nonzero_write;
        @(posedge mclk) disable iff (sys_rst || reinit)
        period_wr && host_wdata != 8'h00 |=> inactivity_timeout_out_n
            && countdown == $past(host_wdata);
    endproperty
    a_nonzero_write: assert property (p_nonzero_write)
        else $error("nonzero write did not load and release");

    property p_expire;
        @(posedge mclk) disable iff (sys_rst)
        $fell(inactivity_timeout_out_n) |-> state == WD_EXPIRED
            && countdown == 8'h00;
    endproperty
    a_expire: assert property (p_expire)
        else $error("timeout asserted without expiry");

    property p_reload;
        @(posedge mclk) disable iff (sys_rst || reinit || period_wr)
        state == WD_COUNT && |trig_hit |=> countdown == $past(timeout_period);
    endproperty
    a_reload: assert property (p_reload)
        else $error("trigger did not reload countdown");

    property p_activate;
        @(posedge mclk) disable iff (sys_rst)
        pm_activate |=> timeout_period == 8'h00 && trigger_config == 4'h0;
    endproperty
    a_activate: assert property (p_activate)
        else $error("activation did not clear watchdog registers");

    property p_soft_reset;
        @(posedge mclk) disable iff (sys_rst)
        soft_reset |=> !pm_active && state == WD_IDLE;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("software reset missed");
endmodule : pmwd_top
`default_nettype wire

// [bench/pmwd_host.sv]
/*
 * pmwd_host: host software model on the index/data port pair.
 * Assumes mclk is free running; strobes change on the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module pmwd_host (
    // clock
    input wire logic mclk,
    // host index/data port
    output logic host_sel,
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata
);
    // --------------------------------------------------------------
    // port cycles
    // --------------------------------------------------------------
    // idle port at time zero
    initial
    begin
        host_sel = 1'b0;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 8'h00;
    end
    // one-cycle strobe; read data taken once the edge has landed
    task automatic cyc(input logic sel, input logic rd,
                       input logic [7:0] d, output logic [7:0] q);
        @(negedge mclk);
        host_sel = sel;
        host_wr = !rd;
        host_rd = rd;
        host_wdata = d;
        @(negedge mclk);
        host_wr = 1'b0;
        host_rd = 1'b0;
        q = host_rdata;
    endtask : cyc
    // index first, then data port
    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        cyc(1'b0, 1'b0, idx, q);
        cyc(1'b1, 1'b0, d, q);
    endtask : wr_reg
    // index first, then read data port
    task automatic rd_reg(input logic [7:0] idx, output logic [7:0] q);
        cyc(1'b0, 1'b0, idx, q);
        cyc(1'b1, 1'b1, 8'h00, q);
    endtask : rd_reg
endmodule : pmwd_host
`default_nettype wire

// [bench/testbench.sv]
/*
 * testbench: self-checking bench for pmwd_top.
 * Assumes a shortened minute of MIN cycles and the host model.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pmwd_pkg::*;
    localparam int MIN = 10; // short minute keeps the run brief
    // --------------------------------------------------------------
    // signals
    // --------------------------------------------------------------
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic soft_reset = 1'b0;
    logic pm_activate = 1'b0;
    logic [2:0] cfg = 3'h0; // first, second, parallel config bits
    logic [1:0] busy = 2'h0; // first, second busy
    logic [3:0] irq = 4'h0; // same order as trigger enable bits
    logic host_sel, host_wr, host_rd, pm_active, out_n;
    logic [7:0] host_wdata, host_rdata, q;
    logic [2:0] clk_en;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #12.5 mclk = ~mclk;
    // --------------------------------------------------------------
    // instances
    // --------------------------------------------------------------
    pmwd_host pmwd_host_inst (.mclk(mclk), .host_sel(host_sel),
        .host_wr(host_wr), .host_rd(host_rd),
        .host_wdata(host_wdata), .host_rdata(host_rdata));
    pmwd_top #(.MINUTE_CYCLES(32'd10)) pmwd_top_inst (.mclk(mclk),
        .sys_rst(sys_rst), .host_sel(host_sel), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .soft_reset(soft_reset),
        .pm_activate(pm_activate), .pm_active(pm_active),
        .parallel_cfg_clk_en(cfg[0]), .second_serial_cfg_clk_en(cfg[1]),
        .first_serial_cfg_clk_en(cfg[2]), .second_serial_busy(busy[0]),
        .first_serial_busy(busy[1]), .parallel_clk_en(clk_en[0]),
        .second_serial_clk_en(clk_en[1]), .first_serial_clk_en(clk_en[2]),
        .keyboard_irq_active(irq[0]), .mouse_irq_active(irq[1]),
        .first_serial_irq_active(irq[2]),
        .second_serial_irq_active(irq[3]),
        .inactivity_timeout_out_n(out_n));
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk
    // wait for the timeout to fire, counting falling edges
    task automatic wait_low(output int n);
        n = 0;
        while (out_n !== 1'b0 && n < 400)
        begin
            @(negedge mclk);
            n++;
        end
    endtask : wait_low
    // one-cycle pulse on a control input
    task automatic pulse(input int which);
        @(negedge mclk);
        if (which == 0) soft_reset = 1'b1;
        else pm_activate = 1'b1;
        @(negedge mclk);
        soft_reset = 1'b0;
        pm_activate = 1'b0;
    endtask : pulse
    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    // reset values, index width, reserved bits
    task automatic t_regs();
        pmwd_host_inst.rd_reg(8'h04, q); chk("gate", 8'h0e, q);
        pmwd_host_inst.rd_reg(8'h05, q); chk("period", 8'h00, q);
        pmwd_host_inst.rd_reg(8'h06, q); chk("trig", 8'h00, q);
        pmwd_host_inst.rd_reg(8'h07, q); chk("stat", 8'h01, q);
        pmwd_host_inst.cyc(1'b0, 1'b0, 8'hff, q);
        pmwd_host_inst.cyc(1'b0, 1'b1, 8'h00, q);
        chk("index", 8'h07, q);
        pmwd_host_inst.rd_reg(8'h00, q); chk("unmapped", 8'h00, q);
        pmwd_host_inst.wr_reg(8'h04, 8'hf1);
        pmwd_host_inst.rd_reg(8'h04, q); chk("gate rsv", 8'h00, q);
        pmwd_host_inst.wr_reg(8'h06, 8'hf0);
        pmwd_host_inst.rd_reg(8'h06, q); chk("trig rsv", 8'h00, q);
        pmwd_host_inst.wr_reg(8'h07, 8'hfe);
        pmwd_host_inst.rd_reg(8'h07, q); chk("stat ro", 8'h01, q);
    endtask : t_regs
    // every gate bit against every config bit, then busy flags
    task automatic t_gates();
        for (int k = 0; k < 8; k++)
        begin
            pmwd_host_inst.wr_reg(8'h04, 8'({k[2:0], 1'b0}));
            for (int c = 0; c < 8; c++)
            begin
                @(negedge mclk);
                cfg = c[2:0];
                repeat (2) @(negedge mclk);
                chk("clk_en", 8'(k[2:0] & c[2:0]),
                    8'(clk_en));
            end
        end
        for (int b = 1; b < 4; b++)
        begin
            @(negedge mclk);
            busy = b[1:0];
            pmwd_host_inst.rd_reg(8'h04, q);
            chk("busy", 8'({b[1:0], 6'h0e}), q);
        end
        busy = 2'h0;
    endtask : t_gates
    // countdown, expiry, stop, rearm and disable
    task automatic t_count();
        int n;
        pmwd_host_inst.wr_reg(8'h05, 8'h03);
        pmwd_host_inst.rd_reg(8'h05, q); chk("prog", 8'h03, q);
        wait_low(n);
        chk("expiry", 8'h01, 8'(n >= 3*MIN-8 && n <= 3*MIN+2));
        pmwd_host_inst.rd_reg(8'h07, q);
        chk("stat act", 8'h00, q);
        repeat (4*MIN) @(negedge mclk);
        chk("held", 8'h00, 8'(out_n));
        pmwd_host_inst.wr_reg(8'h05, 8'h05);
        chk("rearm", 8'h01, 8'(out_n));
        pmwd_host_inst.wr_reg(8'h05, 8'h00);
        repeat (7*MIN) @(negedge mclk);
        chk("stopped", 8'h01, 8'(out_n));
        pmwd_host_inst.wr_reg(8'h05, 8'h01);
        wait_low(n);
        pmwd_host_inst.wr_reg(8'h05, 8'h00);
        chk("zero wr", 8'h01, 8'(out_n));
    endtask : t_count
    // each trigger source reloads; other sources are ignored
    task automatic t_trig();
        int n;
        for (int s = 0; s < 4; s++)
        begin
            pmwd_host_inst.wr_reg(8'h06, 8'(1 << s));
            pmwd_host_inst.wr_reg(8'h05, 8'h02);
            repeat (6)
            begin
                repeat (14) @(negedge mclk);
                irq = 4'(1 << s);
                @(negedge mclk);
                irq = 4'h0;
            end
            chk("kept", 8'h01, 8'(out_n));
            @(negedge mclk);
            irq = ~4'(1 << s);
            wait_low(n);
            irq = 4'h0;
            chk("lapse", 8'h01,
                8'(n >= 2*MIN-3 && n <= 2*MIN+2));
            pmwd_host_inst.wr_reg(8'h05, 8'h00);
        end
    endtask : t_trig
    // activation and software reset clear the watchdog
    task automatic t_dev();
        pmwd_host_inst.wr_reg(8'h06, 8'h0f);
        pmwd_host_inst.wr_reg(8'h05, 8'h01);
        repeat (2*MIN) @(negedge mclk);
        pulse(1);
        chk("active", 8'h01, 8'(pm_active));
        chk("out act", 8'h01, 8'(out_n));
        pmwd_host_inst.rd_reg(8'h05, q); chk("act per", 8'h00, q);
        pmwd_host_inst.rd_reg(8'h06, q); chk("act trig", 8'h00, q);
        pmwd_host_inst.rd_reg(8'h07, q); chk("act stat", 8'h01, q);
        pmwd_host_inst.wr_reg(8'h05, 8'h01);
        pulse(0);
        chk("inactive", 8'h00, 8'(pm_active));
        repeat (3*MIN) @(negedge mclk);
        chk("sw reset", 8'h01, 8'(out_n));
    endtask : t_dev
    // --------------------------------------------------------------
    // verdict and main sequence
    // --------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // hang guard, well beyond the whole sequence
    initial
    begin
        #(25 * 20000);
        n_mismatch++;
        print_verdict();
    end
    initial
    begin
        repeat (5) @(negedge mclk);
        sys_rst = 1'b0;
        t_regs();
        t_gates();
        t_count();
        t_trig();
        t_dev();
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
